// *** rtl/kwd_top.sv ***
`timescale 1ns/100ps
`include "kwd_cfg.svh"
module kwd_top
   import kwd_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic        external_reset_n_i,
   input  wire logic        disable_unlock_i,
   input  wire logic        cpu_halt_i,
   input  wire logic        run_free_i,
   input  wire logic        rt_step_i,
   input  wire logic        rt_free_i,
   input  wire logic        wake_enable_i,
   input  wire logic [1:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   output logic             watchdog_reset_out_n_o,
   output logic             watchdog_wake_out_n_o
);

   kwd_ctrl_t st_r;
   kwd_ctrl_t st_nxt;
   logic      blk_reset;
   logic      fire;
   logic      key_wr;
   logic      ctrl_wr;
   logic      guard_bad;

   kwd_link_if link ();

   // Control state is also cleared by the external line; the pulse
   // generator is not, so a looped-back pulse cannot cut itself short
   assign blk_reset = reset_i || !external_reset_n_i;

   assign key_wr    = wr_i && (addr_i == `KWD_ADDR_KEY);
   assign ctrl_wr   = wr_i && (addr_i == `KWD_ADDR_CTRL);
   assign guard_bad = wdata_i[`KWD_GUARD_RANGE] != `KWD_GUARD_OK;

   // Single-step wins over any free-run request; a plain halt is lifted
   // by either run-free mode
   assign link.stop = rt_step_i || (cpu_halt_i && !run_free_i && !rt_free_i);
   assign link.count_prescale = st_r.count_prescale;
   assign link.wake_enable    = wake_enable_i;
   assign link.fire           = fire;

   kwd_presc u_presc (
      .clock_i (clock_i),
      .reset_i (blk_reset),
      .lnk     (link)
   );

   kwd_pulse u_pulse (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .lnk     (link)
   );

   assign watchdog_reset_out_n_o = link.reset_out_n;
   assign watchdog_wake_out_n_o  = link.wake_out_n;
   assign rdata_o                = st_r.rdata;

   always_comb begin
      st_nxt = st_r;
      fire   = 1'b0;

      if (link.count_clock && !st_r.watchdog_disable) begin
         if (st_r.watchdog_count == `KWD_COUNT_MAX) begin
            fire = 1'b1;
         end
         st_nxt.watchdog_count = st_r.watchdog_count + `KWD_COUNT_STEP;
      end

      if (key_wr) begin
         case (wdata_i[`KWD_KEY_RANGE])
            `KWD_KEY_ARM: begin
               st_nxt.armed = 1'b1;
            end
            `KWD_KEY_SERVE: begin
               // A lone 0xAA is a legal key but clears nothing
               if (st_r.armed) begin
                  st_nxt.watchdog_count = `KWD_COUNT_RESET;
               end
               st_nxt.armed = 1'b0;
            end
            default: begin
               fire         = 1'b1;
               st_nxt.armed = 1'b0;
            end
         endcase
      end

      if (ctrl_wr) begin
         st_nxt.count_prescale = wdata_i[`KWD_PS_RANGE];
         if (disable_unlock_i) begin
            st_nxt.watchdog_disable = wdata_i[`KWD_DIS_BIT];
         end
         // Guard is judged against the enable in force before this write
         if (guard_bad && !st_r.watchdog_disable) begin
            fire = 1'b1;
         end
         if (wdata_i[`KWD_FLAG_BIT]) begin
            st_nxt.reset_cause_flag = 1'b0;
         end
      end

      // Set after clear so a coincident event is kept
      if (link.edge_seen && external_reset_n_i) begin
         st_nxt.reset_cause_flag = 1'b1;
      end

      st_nxt.rdata = `KWD_RDATA_ZERO;
      if (rd_i) begin
         case (addr_i)
            `KWD_ADDR_CTRL: begin
               st_nxt.rdata[`KWD_FLAG_BIT] = st_r.reset_cause_flag;
               st_nxt.rdata[`KWD_DIS_BIT]  = st_r.watchdog_disable;
               st_nxt.rdata[`KWD_PS_RANGE] = st_r.count_prescale;
            end
            `KWD_ADDR_COUNT: begin
               st_nxt.rdata[`KWD_KEY_RANGE] = st_r.watchdog_count;
            end
            default: begin
               st_nxt.rdata = `KWD_RDATA_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (blk_reset) begin
         st_r <= '{watchdog_count: `KWD_COUNT_RESET, count_prescale: `KWD_PS_RESET,
                   watchdog_disable: 1'b0, reset_cause_flag: 1'b0, armed: 1'b0,
                   rdata: `KWD_RDATA_ZERO};
      end else begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (blk_reset);

   property p_key_clear;
      key_wr && (wdata_i[`KWD_KEY_RANGE] == `KWD_KEY_SERVE) && st_r.armed |=>
         st_r.watchdog_count == `KWD_COUNT_RESET && !st_r.armed;
   endproperty
   a_key_clear: assert property (p_key_clear) else $error("key pair did not clear");

   property p_lone_serve;
      key_wr && (wdata_i[`KWD_KEY_RANGE] == `KWD_KEY_SERVE) && !st_r.armed &&
         !link.count_clock |=> st_r.watchdog_count == $past(st_r.watchdog_count);
   endproperty
   a_lone_serve: assert property (p_lone_serve) else $error("unarmed key cleared");

   property p_bad_key;
      key_wr && (wdata_i[`KWD_KEY_RANGE] != `KWD_KEY_ARM) &&
         (wdata_i[`KWD_KEY_RANGE] != `KWD_KEY_SERVE) && link.reset_out_n |=>
         !link.reset_out_n;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("bad key gave no reset");

   property p_guard;
      ctrl_wr && guard_bad && !st_r.watchdog_disable && link.reset_out_n |=>
         !link.reset_out_n [*8];
   endproperty
   a_guard: assert property (p_guard) else $error("bad guard gave no reset");

   property p_dis_write;
      ctrl_wr && disable_unlock_i |=> st_r.watchdog_disable == $past(wdata_i[`KWD_DIS_BIT]);
   endproperty
   a_dis_write: assert property (p_dis_write) else $error("disable bit not written");

   property p_dis_locked;
      !disable_unlock_i |=> $stable(st_r.watchdog_disable);
   endproperty
   a_dis_locked: assert property (p_dis_locked) else $error("locked disable changed");

   property p_after_reset;
      @(posedge clock_i) disable iff (reset_i)
      $fell(blk_reset) |-> !st_r.watchdog_disable && st_r.watchdog_count == `KWD_COUNT_RESET
         && st_r.count_prescale == `KWD_PS_RESET;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("bad state after reset");

   property p_flag_hold;
      !(ctrl_wr && wdata_i[`KWD_FLAG_BIT]) && st_r.reset_cause_flag |=> st_r.reset_cause_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

   property p_flag_ext_low;
      @(posedge clock_i) disable iff (reset_i)
      !external_reset_n_i |=> !st_r.reset_cause_flag;
   endproperty
   a_flag_ext_low: assert property (p_flag_ext_low) else $error("flag set in ext reset");

   property p_flag_set;
      link.edge_seen && external_reset_n_i |=> st_r.reset_cause_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set by pulse");

   property p_stop;
      link.stop && !key_wr |=> $stable(st_r.watchdog_count);
   endproperty
   a_stop: assert property (p_stop) else $error("counter moved while halted");

   property p_overflow;
      link.count_clock && !st_r.watchdog_disable && st_r.watchdog_count == `KWD_COUNT_MAX
         && link.reset_out_n |=> !link.reset_out_n && st_r.watchdog_count == `KWD_COUNT_RESET;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow gave no reset");

   property p_read_zero;
      rd_i && (addr_i == `KWD_ADDR_KEY) |=> rdata_o == `KWD_RDATA_ZERO;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("key read not zero");

   property p_count_step;
      link.count_clock && !st_r.watchdog_disable && !key_wr |=>
         st_r.watchdog_count == $past(st_r.watchdog_count) + `KWD_COUNT_STEP;
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter missed a tick");

   property p_dis_hold;
      st_r.watchdog_disable && !key_wr |=> $stable(st_r.watchdog_count);
   endproperty
   a_dis_hold: assert property (p_dis_hold) else $error("disabled counter moved");

   property p_disabled_quiet;
      st_r.watchdog_disable && !key_wr |-> !fire;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled block fired");

   // Both legal keys must stay silent unless an overflow lands in the same cycle
   property p_serve_quiet;
      key_wr && ((wdata_i[`KWD_KEY_RANGE] == `KWD_KEY_ARM) ||
         (wdata_i[`KWD_KEY_RANGE] == `KWD_KEY_SERVE)) && link.reset_out_n &&
         !(link.count_clock && !st_r.watchdog_disable && st_r.watchdog_count == `KWD_COUNT_MAX)
         |=> link.reset_out_n;
   endproperty
   a_serve_quiet: assert property (p_serve_quiet) else $error("legal key gave a reset");

   property p_arm;
      key_wr && (wdata_i[`KWD_KEY_RANGE] == `KWD_KEY_ARM) |=> st_r.armed;
   endproperty
   a_arm: assert property (p_arm) else $error("first key did not arm");

   property p_ps_write;
      ctrl_wr |=> st_r.count_prescale == $past(wdata_i[`KWD_PS_RANGE]);
   endproperty
   a_ps_write: assert property (p_ps_write) else $error("prescale not written");

   property p_ctrl_read;
      rd_i && (addr_i == `KWD_ADDR_CTRL) |=> rdata_o[`KWD_GUARD_RANGE] == '0;
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("guard field read nonzero");

   property p_flag_clear;
      ctrl_wr && wdata_i[`KWD_FLAG_BIT] && !link.edge_seen |=> !st_r.reset_cause_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write");

   property p_flag_ext_edge;
      @(posedge clock_i) disable iff (reset_i)
      link.edge_seen && !external_reset_n_i |=> !st_r.reset_cause_flag;
   endproperty
   a_flag_ext_edge: assert property (p_flag_ext_edge) else $error("flag set under ext reset");

   property p_step_frozen;
      rt_step_i |-> !link.count_clock;
   endproperty
   a_step_frozen: assert property (p_step_frozen) else $error("count clock in single-step");

   property p_wake_gate;
      $fell(link.reset_out_n) |-> link.wake_out_n == !$past(wake_enable_i);
   endproperty
   a_wake_gate: assert property (p_wake_gate) else $error("wake output not gated");

   c_service: cover property (key_wr && wdata_i[`KWD_KEY_RANGE] == `KWD_KEY_SERVE && st_r.armed);
   c_overflow: cover property (link.count_clock && st_r.watchdog_count == `KWD_COUNT_MAX);
   c_flag: cover property (link.edge_seen && external_reset_n_i);
   c_halt: cover property (link.stop && link.count_prescale != `KWD_PS_RESET);
   c_wake: cover property ($fell(link.reset_out_n) && !link.wake_out_n);

endmodule : kwd_top

// *** rtl/kwd_cfg.svh ***
`ifndef KWD_CFG_SVH
`define KWD_CFG_SVH

`define KWD_ADDR_KEY      2'h0
`define KWD_ADDR_CTRL     2'h1
`define KWD_ADDR_COUNT    2'h2

`define KWD_KEY_RANGE     7:0
`define KWD_KEY_ARM       8'h55
`define KWD_KEY_SERVE     8'hAA

`define KWD_PS_RANGE      2:0
`define KWD_GUARD_RANGE   5:3
`define KWD_DIS_BIT       6
`define KWD_FLAG_BIT      7
`define KWD_GUARD_OK      3'h5

`define KWD_PS_RESET      3'h0
`define KWD_PS_STEP       3'h1
`define KWD_COUNT_RESET   8'h00
`define KWD_COUNT_MAX     8'hFF
`define KWD_COUNT_STEP    8'h01
`define KWD_RDATA_ZERO    16'h0000

`define KWD_BASE_W        9
`define KWD_BASE_ONES     9'h1FF
`define KWD_BASE_STEP     9'h001
`define KWD_STAGE_W       6
`define KWD_STAGE_STEP    6'h01
`define KWD_BASE_PERIOD   16'h0200

`define KWD_PULSE_LAST    9'h1FF
`define KWD_PULSE_STEP    9'h001
`define KWD_PULSE_CYCLES  10'h200
`define KWD_FLAG_DELAY    4

`endif

// *** rtl/kwd_pkg.sv ***
package kwd_pkg;
`include "kwd_cfg.svh"

   typedef enum logic {PL_IDLE, PL_LOW} kwd_pulse_state_t;

   typedef struct packed {
      logic [7:0]  watchdog_count;
      logic [2:0]  count_prescale;
      logic        watchdog_disable;
      logic        reset_cause_flag;
      logic        armed;
      logic [15:0] rdata;
   } kwd_ctrl_t;

   typedef struct packed {
      logic [`KWD_BASE_W-1:0]  base;
      logic [`KWD_STAGE_W-1:0] stage;
   } kwd_presc_t;

   typedef struct packed {
      kwd_pulse_state_t          state;
      logic [8:0]                cnt;
      logic                      wake;
      logic                      sync_a;
      logic                      sync_b;
      logic                      sync_c;
      logic [`KWD_FLAG_DELAY-1:0] dly;
   } kwd_pulse_t;

endpackage : kwd_pkg

// *** rtl/kwd_link_if.sv ***
`timescale 1ns/100ps
interface kwd_link_if;
   logic [2:0] count_prescale;
   logic       stop;
   logic       count_clock;
   logic       fire;
   logic       wake_enable;
   logic       reset_out_n;
   logic       wake_out_n;
   logic       edge_seen;

   modport presc_mp (input count_prescale, stop, output count_clock);
   modport pulse_mp (input fire, wake_enable, output reset_out_n, wake_out_n, edge_seen);
endinterface : kwd_link_if

// *** rtl/kwd_presc.sv ***
`timescale 1ns/100ps
`include "kwd_cfg.svh"
module kwd_presc
   import kwd_pkg::*;
(
   input  wire logic    clock_i,
   input  wire logic    reset_i,
   kwd_link_if.presc_mp lnk
);

   kwd_presc_t              st_r;
   kwd_presc_t              st_nxt;
   logic [2:0]              shift_k;
   logic [`KWD_STAGE_W-1:0] stage_mask;

   // Codes 000 and 001 both give the plain divide by 512
   assign shift_k = (lnk.count_prescale == `KWD_PS_RESET) ? `KWD_PS_RESET :
                    lnk.count_prescale - `KWD_PS_STEP;

   genvar gi;
   for (gi = 0; gi < `KWD_STAGE_W; gi++) begin : g_mask
      assign stage_mask[gi] = (shift_k > 3'(gi));
   end

   assign lnk.count_clock = !lnk.stop && (st_r.base == `KWD_BASE_ONES) &&
                            ((st_r.stage & stage_mask) == stage_mask);

   always_comb begin
      st_nxt = st_r;
      // Divider freezes while halted so the count clock is truly stopped
      if (!lnk.stop) begin
         st_nxt.base = st_r.base + `KWD_BASE_STEP;
         if (st_r.base == `KWD_BASE_ONES) begin
            st_nxt.stage = st_r.stage + `KWD_STAGE_STEP;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st_r <= '{base: '0, stage: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   logic [15:0] gap_r;
   logic        seen_r;
   logic [2:0]  ps_q_r;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         gap_r  <= '0;
         seen_r <= 1'b0;
         ps_q_r <= `KWD_PS_RESET;
      end else begin
         ps_q_r <= lnk.count_prescale;
         if (lnk.count_prescale != ps_q_r) begin
            seen_r <= 1'b0;
            gap_r  <= '0;
         end else if (lnk.count_clock) begin
            seen_r <= 1'b1;
            gap_r  <= '0;
         end else if (!lnk.stop) begin
            gap_r <= gap_r + 16'h0001;
         end
      end
   end

   property p_tick_period;
      @(posedge clock_i) disable iff (reset_i)
      lnk.count_clock && seen_r && (lnk.count_prescale == ps_q_r) |->
         (gap_r + 16'h0001) == (`KWD_BASE_PERIOD << shift_k);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("count clock period wrong");

endmodule : kwd_presc

// *** rtl/kwd_pulse.sv ***
`timescale 1ns/100ps
`include "kwd_cfg.svh"
module kwd_pulse
   import kwd_pkg::*;
(
   input  wire logic    clock_i,
   input  wire logic    reset_i,
   kwd_link_if.pulse_mp lnk
);

   kwd_pulse_t st_r;
   kwd_pulse_t st_nxt;

   assign lnk.reset_out_n = (st_r.state == PL_IDLE);
   assign lnk.wake_out_n  = !st_r.wake;
   assign lnk.edge_seen   = st_r.dly[`KWD_FLAG_DELAY-1];

   always_comb begin
      st_nxt = st_r;
      case (st_r.state)
         PL_IDLE: begin
            // A second trigger during a pulse is absorbed, not stretched
            if (lnk.fire) begin
               st_nxt.state = PL_LOW;
               st_nxt.cnt   = '0;
               st_nxt.wake  = lnk.wake_enable;
            end
         end
         PL_LOW: begin
            if (st_r.cnt == `KWD_PULSE_LAST) begin
               st_nxt.state = PL_IDLE;
               st_nxt.wake  = 1'b0;
            end else begin
               st_nxt.cnt = st_r.cnt + `KWD_PULSE_STEP;
            end
         end
         default: begin
            st_nxt.state = PL_IDLE;
         end
      endcase
      // Own output is resynchronised so the flag sees what leaves the block
      st_nxt.sync_a = (st_r.state == PL_IDLE);
      st_nxt.sync_b = st_r.sync_a;
      st_nxt.sync_c = st_r.sync_b;
      st_nxt.dly    = {st_r.dly[`KWD_FLAG_DELAY-2:0], st_r.sync_b & !st_r.sync_c};
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st_r <= '{state: PL_IDLE, cnt: '0, wake: 1'b0, sync_a: 1'b1,
                   sync_b: 1'b1, sync_c: 1'b1, dly: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   logic [9:0] low_len_r;

   always_ff @(posedge clock_i) begin
      if (reset_i || lnk.reset_out_n) begin
         low_len_r <= '0;
      end else begin
         low_len_r <= low_len_r + 10'h001;
      end
   end

   property p_pulse_len;
      @(posedge clock_i) disable iff (reset_i)
      $rose(lnk.reset_out_n) |-> low_len_r == `KWD_PULSE_CYCLES;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

   property p_wake_in_pulse;
      @(posedge clock_i) disable iff (reset_i)
      !lnk.wake_out_n |-> !lnk.reset_out_n;
   endproperty
   a_wake_in_pulse: assert property (p_wake_in_pulse) else $error("wake outside pulse");

   property p_edge_delay;
      @(posedge clock_i) disable iff (reset_i)
      $rose(lnk.reset_out_n) |-> ##6 lnk.edge_seen;
   endproperty
   a_edge_delay: assert property (p_edge_delay) else $error("edge not seen after delay");

endmodule : kwd_pulse

// *** bench/kwd_reset_model.sv ***
`timescale 1ns/100ps
// Device reset logic beside the watchdog: either a plain pulse on request, or
// the watchdog output wired back onto the external reset line.
module kwd_reset_model (
   input  wire logic       clock_i,
   input  wire logic       watchdog_n_i,
   input  wire logic       follow_i,
   input  wire logic [9:0] extra_i,
   input  wire logic       pulse_i,
   output logic            external_reset_n_o
);
   logic [10:0] hold_r = 11'h000;

   always_ff @(posedge clock_i) begin
      if (pulse_i) begin
         hold_r <= 11'h020;
      end else if (follow_i && !watchdog_n_i) begin
         // Stretching more than 6 cycles past the watchdog pulse hides the watchdog cause from software
         hold_r <= {1'b0, extra_i} + 11'h001;
      end else if (hold_r != 11'h000) begin
         hold_r <= hold_r - 11'h001;
      end
   end

   assign external_reset_n_o = (hold_r == 11'h000);
endmodule : kwd_reset_model

// *** bench/test_keyed_watchdog_timer.sv ***
`timescale 1ns/100ps
`include "kwd_cfg.svh"
module test_keyed_watchdog_timer;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        ext_n;
   logic        unlock = 1'b0;
   logic        halt = 1'b0;
   logic        run_free = 1'b0;
   logic        rt_step = 1'b0;
   logic        rt_free = 1'b0;
   logic        wake_en = 1'b0;
   logic [1:0]  addr = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] rdata;
   logic        rst_n;
   logic        wake_n;
   logic        follow = 1'b0;
   logic [9:0]  extra = 10'h000;
   logic        ext_pulse = 1'b0;
   int          fail_count = 0;
   int          check_count = 0;
   logic [15:0] cv;
   logic [3:0]  modes [5] = '{4'b1000, 4'b1100, 4'b0010, 4'b0110, 4'b1001};
   logic [15:0] mode_ticks [5] = '{16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0002};

   kwd_top kwd_top_i (
      .clock_i(clock_i), .reset_i(reset_i), .external_reset_n_i(ext_n),
      .disable_unlock_i(unlock), .cpu_halt_i(halt), .run_free_i(run_free),
      .rt_step_i(rt_step), .rt_free_i(rt_free), .wake_enable_i(wake_en),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .watchdog_reset_out_n_o(rst_n), .watchdog_wake_out_n_o(wake_n));

   kwd_reset_model kwd_reset_model_i (
      .clock_i(clock_i), .watchdog_n_i(rst_n), .follow_i(follow),
      .extra_i(extra), .pulse_i(ext_pulse), .external_reset_n_o(ext_n));

   always #10 clock_i = ~clock_i;

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk16

   task automatic idle(input int n);
      repeat (n) @(posedge clock_i);
   endtask : idle

   task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_read

   task automatic rd_chk(input string n, input logic [1:0] a, input logic [15:0] e);
      logic [15:0] d;
      reg_read(a, d);
      chk16(n, e, d);
   endtask : rd_chk

   // Two count reads exactly gap cycles apart, so the divider phase drops out
   task automatic rate_chk(input string n, input int gap, input logic [15:0] e);
      logic [15:0] a;
      logic [15:0] b;
      reg_read(`KWD_ADDR_COUNT, a);
      idle(gap - 2);
      reg_read(`KWD_ADDR_COUNT, b);
      chk16(n, e, b - a);
   endtask : rate_chk

   // Called right after the edge that took the offending write
   task automatic pulse_chk(input logic [15:0] exp_wake);
      logic [15:0] nr;
      logic [15:0] nw;
      nr = 16'h0000;
      nw = 16'h0000;
      #1;
      chk16("reset_at_once", 16'h0000, {15'h0000, rst_n});
      repeat (600) begin
         if (rst_n === 1'b0) nr++;
         if (wake_n === 1'b0) nw++;
         @(posedge clock_i);
         #1;
      end
      chk16("reset_low_cycles", 16'h0200, nr);
      chk16("wake_low_cycles", exp_wake, nw);
   endtask : pulse_chk

   task automatic set_mode(input logic [3:0] m);
      @(posedge clock_i);
      {halt, run_free, rt_step, rt_free} <= m;
   endtask : set_mode

   initial begin
      idle(2);
      reset_i <= 1'b0;
      rd_chk("ctrl_reset", `KWD_ADDR_CTRL, 16'h0000);
      rd_chk("count_reset", `KWD_ADDR_COUNT, 16'h0000);
      rd_chk("key_read", `KWD_ADDR_KEY, 16'h0000);
      rd_chk("unmapped", 2'h3, 16'h0000);
      for (int code = 0; code < 6; code++) begin
         reg_write(`KWD_ADDR_CTRL, 16'h0028 | 16'(code));
         rd_chk("prescale", `KWD_ADDR_CTRL, 16'(code));
         rate_chk("ticks", 1024 << (code <= 1 ? 0 : code - 1), 16'h0002);
      end
      // The two slowest codes get a one-period window to keep the run short
      for (int code = 6; code < 8; code++) begin
         reg_write(`KWD_ADDR_CTRL, 16'h0028 | 16'(code));
         rd_chk("prescale", `KWD_ADDR_CTRL, 16'(code));
         rate_chk("ticks_slow", 512 << (code - 1), 16'h0001);
      end
      reg_write(`KWD_ADDR_CTRL, 16'h0028);
      for (int i = 0; i < 5; i++) begin
         set_mode(modes[i]);
         rate_chk("debug_ticks", 1024, mode_ticks[i]);
      end
      set_mode(4'b1000);
      reg_read(`KWD_ADDR_COUNT, cv);
      chk16("count_moved", 16'h0001, {15'h0000, cv != 16'h0000});
      reg_write(`KWD_ADDR_KEY, 16'h00AA);
      rd_chk("unarmed_serve", `KWD_ADDR_COUNT, cv);
      chk16("no_reset", 16'h0001, {15'h0000, rst_n});
      reg_write(`KWD_ADDR_COUNT, 16'h00AB);
      rd_chk("count_ro", `KWD_ADDR_COUNT, cv);
      reg_write(`KWD_ADDR_KEY, 16'h0055);
      reg_write(`KWD_ADDR_CTRL, 16'h0028);
      reg_write(`KWD_ADDR_KEY, 16'h00AA);
      rd_chk("served", `KWD_ADDR_COUNT, 16'h0000);
      reg_write(`KWD_ADDR_CTRL, 16'h0068);
      rd_chk("locked", `KWD_ADDR_CTRL, 16'h0000);
      @(posedge clock_i);
      unlock <= 1'b1;
      reg_write(`KWD_ADDR_CTRL, 16'h0068);
      rd_chk("disabled", `KWD_ADDR_CTRL, 16'h0040);
      set_mode(4'b0000);
      rate_chk("held", 1024, 16'h0000);
      reg_write(`KWD_ADDR_CTRL, 16'h0042);
      #1;
      chk16("guard_off", 16'h0001, {15'h0000, rst_n});
      rd_chk("guard_off_fields", `KWD_ADDR_CTRL, 16'h0042);
      reg_write(`KWD_ADDR_CTRL, 16'h0028);
      rd_chk("enabled", `KWD_ADDR_CTRL, 16'h0000);
      @(posedge clock_i);
      unlock <= 1'b0;
      wake_en <= 1'b1;
      reg_write(`KWD_ADDR_KEY, 16'h0012);
      pulse_chk(16'h0200);
      rd_chk("flag_set", `KWD_ADDR_CTRL, 16'h0080);
      reg_write(`KWD_ADDR_CTRL, 16'h0028);
      rd_chk("flag_kept", `KWD_ADDR_CTRL, 16'h0080);
      reg_write(`KWD_ADDR_CTRL, 16'h00A8);
      rd_chk("flag_clear", `KWD_ADDR_CTRL, 16'h0000);
      @(posedge clock_i);
      wake_en <= 1'b0;
      reg_write(`KWD_ADDR_CTRL, 16'h0000);
      pulse_chk(16'h0000);
      rd_chk("flag_guard", `KWD_ADDR_CTRL, 16'h0080);
      @(posedge clock_i);
      ext_pulse <= 1'b1;
      @(posedge clock_i);
      ext_pulse <= 1'b0;
      // Read after the line is high again, else the reset itself zeroes the read data
      idle(40);
      rd_chk("flag_ext_low", `KWD_ADDR_CTRL, 16'h0000);
      @(posedge clock_i);
      follow <= 1'b1;
      reg_write(`KWD_ADDR_KEY, 16'h0012);
      pulse_chk(16'h0000);
      rd_chk("flag_wired", `KWD_ADDR_CTRL, 16'h0080);
      reg_write(`KWD_ADDR_CTRL, 16'h00A8);
      @(posedge clock_i);
      extra <= 10'h258;
      reg_write(`KWD_ADDR_KEY, 16'h0012);
      pulse_chk(16'h0000);
      idle(600);
      rd_chk("flag_long_ext", `KWD_ADDR_CTRL, 16'h0000);
      give_verdict();
   end

   // The full sequence needs about 91000 cycles
   initial begin
      idle(96000);
      fail_count++;
      give_verdict();
   end
endmodule : test_keyed_watchdog_timer
